// >>> srtc_pkg.sv
// Shared constants for the single-wire real-time clock core.
// Assumes a 200 MHz core clock and a 32.768 kHz crystal clock on a pin.
package srtc_pkg;

  // Core clock
  localparam int unsigned CLK_MHZ = 200;

  // Identity code layout
  localparam int unsigned FAMILY_W  = 8;
  localparam int unsigned SERIAL_W  = 48;
  localparam int unsigned CHECK_W   = 8;
  localparam int unsigned ID_BITS   = 64;
  localparam int unsigned CHECK_POS = 56;

  // Check generator, x^8 + x^5 + x^4 + 1, reflected for lsb-first shifting
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
  localparam logic [7:0] CRC_INIT      = 8'h00;

  // Identity-level commands
  localparam logic [7:0] CMD_ID_READOUT  = 8'h33;
  localparam logic [7:0] CMD_ADDR_SELECT = 8'h55;
  localparam logic [7:0] CMD_ENUMERATION = 8'hF0;
  localparam logic [7:0] CMD_BCAST_SEL   = 8'hCC;

  // Clock function commands
  localparam logic [7:0] CMD_TIME_FETCH = 8'h66;
  localparam logic [7:0] CMD_TIME_LOAD  = 8'h99;

  // clock_control_byte fields
  localparam int unsigned CTL_RUN_LO   = 2;
  localparam int unsigned CTL_RUN_HI   = 3;
  localparam int unsigned CTL_ISEL_LSB = 4;
  localparam int unsigned CTL_GATE     = 7;
  localparam logic        RST_RUN      = 1'b0;
  localparam logic [2:0]  RST_ISEL     = 3'h0;
  localparam logic        RST_GATE     = 1'b0;

  // Transfer lengths in bits
  localparam int unsigned BYTE_BITS  = 8;
  localparam int unsigned FRAME_BITS = 40;
  localparam int unsigned BITCNT_W   = 7;

  // Seconds counter and prescaler
  localparam int unsigned SEC_W      = 32;
  localparam int unsigned PRESC_W    = 15;
  localparam logic [14:0] PRESC_LAST = 15'h7FFF;

  // Interval select codes map to power-of-two exponents of seconds
  localparam logic [4:0] ISEL_EXP [8] = '{5'h00, 5'h02, 5'h05, 5'h06,
                                          5'h0B, 5'h0C, 5'h10, 5'h11};

  // Interrupt low pulse
  localparam int unsigned INT_PULSE_US = 100;
  localparam int unsigned INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
  localparam int unsigned INT_CNT_W = 16;

  typedef enum logic [3:0] {
    SRTC_INIT, SRTC_IDLE, SRTC_ROM_CMD, SRTC_ID_READ, SRTC_ADDR_MATCH,
    SRTC_ENUM, SRTC_FN_CMD, SRTC_FETCH, SRTC_LOAD, SRTC_WAIT
  } srtc_state_t;

endpackage : srtc_pkg

// >>> srtc_tk_if.sv
// Carrier between the bus core and the timekeeper.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface srtc_tk_if;
  logic                        osc_en;
  logic [2:0]                  isel;
  logic                        irq_en;
  logic                        snap_req;
  logic                        load_req;
  logic [srtc_pkg::SEC_W-1:0]  load_val;
  logic [srtc_pkg::SEC_W-1:0]  snapshot;
  logic [srtc_pkg::SEC_W-1:0]  count;

  modport core (output osc_en, isel, irq_en, snap_req, load_req, load_val,
                input snapshot, count);
  modport tk   (input osc_en, isel, irq_en, snap_req, load_req, load_val,
                output snapshot, count);
endinterface : srtc_tk_if

// >>> srtc_crc8.sv
// Serial check-byte generator, one bit per shift.
// Assumes the caller feeds bits lsb first.
`timescale 1ns/100ps
module srtc_crc8 (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_clear,
  input  wire logic       i_shift,
  input  wire logic       i_bit,
  output logic [7:0]      o_crc
);
  logic fb;

  assign fb = o_crc[0] ^ i_bit;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_crc <= srtc_pkg::CRC_INIT;
    end else if (i_clear) begin
      o_crc <= srtc_pkg::CRC_INIT; // RULE3
    end else if (i_shift) begin
      o_crc <= (o_crc >> 1) ^ (fb ? srtc_pkg::CRC_POLY_REFL : 8'h00); // RULE2
    end
  end
endmodule : srtc_crc8

// >>> srtc_timekeeper.sv
// Crystal prescaler, seconds counter, snapshot buffer and interrupt pulse.
// Assumes the crystal clock arrives unsynchronised on a pin.
`timescale 1ns/100ps
module srtc_timekeeper #(
  parameter int unsigned INT_PULSE_CYC = srtc_pkg::INT_PULSE_CYC
) (
  input  wire logic   i_clk,
  input  wire logic   i_nrst,
  input  wire logic   i_xtal,
  srtc_tk_if.tk       tk,
  output logic        o_int_low
);
  logic                                xs1, xs2, xs3;
  logic                                tick, sec;
  logic [srtc_pkg::PRESC_W-1:0]        presc;
  logic [srtc_pkg::SEC_W-1:0]          next_count, mask;
  logic [srtc_pkg::INT_CNT_W-1:0]      pulse_cnt;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      xs1 <= 1'b0;
      xs2 <= 1'b0;
      xs3 <= 1'b0;
    end else begin
      xs1 <= i_xtal;
      xs2 <= xs1;
      xs3 <= xs2;
    end
  end

  assign tick = xs2 & ~xs3 & tk.osc_en; // RULE8
  assign sec  = tick && (presc == srtc_pkg::PRESC_LAST);
  assign next_count = tk.count + 32'h0000_0001; // RULE18
  assign mask = (32'h0000_0001 << srtc_pkg::ISEL_EXP[tk.isel]) - 32'h0000_0001; // RULE14

  // One-second prescale of the crystal
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      presc <= '0;
    end else if (tick) begin
      presc <= presc + 15'h0001; // RULE22
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tk.count <= '0;
    end else if (tk.load_req) begin
      tk.count <= tk.load_val; // RULE20
    end else if (sec) begin
      tk.count <= next_count; // RULE18
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tk.snapshot <= '0;
    end else if (tk.snap_req) begin
      tk.snapshot <= tk.count; // RULE9
    end
  end

  // Pulse restarts if a new interval lands inside a running pulse
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pulse_cnt <= '0;
      o_int_low <= 1'b0;
    end else if (sec && tk.irq_en && ((next_count & mask) == 32'h0000_0000)) begin
      pulse_cnt <= INT_PULSE_CYC[srtc_pkg::INT_CNT_W-1:0]; // RULE17 RULE21
      o_int_low <= 1'b1;
    end else if (pulse_cnt > 16'h0001) begin
      pulse_cnt <= pulse_cnt - 16'h0001;
    end else begin
      pulse_cnt <= '0;
      o_int_low <= 1'b0;
    end
  end
endmodule : srtc_timekeeper

// >>> srtc_core.sv
// Top of the single-wire real-time clock core: identity and command layer.
// Assumes a slot layer on i_clk reports bus reset, slot start, sample, end.
//
// Summary of operation
// RULE1 - Fixed 64-bit identity: family byte, 48-bit serial, check byte.
// RULE2 - Check byte from shift register with x^8+x^5+x^4+1 feedback.
// RULE3 - Register cleared first; family shifted in lsb first.
// RULE4 - Serial follows family; register then holds the check byte.
// RULE5 - Shifting in check bits too must return register to zero.
// RULE6 - Every bus byte travels least significant bit first.
// RULE7 - Clock commands accepted only after an identity-level command succeeds.
// RULE8 - Seconds counter advances only while the crystal oscillator is on.
// RULE9 - Counter copied to a snapshot buffer; reads come from the buffer.
// RULE10 - Control byte reached only through the clock function commands.
// RULE11 - Control bits 0 and 1 read zero; writes to them ignored.
// RULE12 - Bits 2 and 3 both read one while oscillator runs, else zero.
// RULE13 - If written run bits differ, bit 3 sets the oscillator.
// RULE14 - Bits 6..4 pick interval 1,4,32,64,2048,4096,65536,131072 seconds.
// RULE15 - Interrupt pin is open drain, only pulled low.
// RULE16 - Data pin is open drain: pulled low or released.
// RULE17 - Interval pulses only while control bit 7 is one.
// RULE18 - Seconds counter is 32 bits, increments each second, wraps.
// RULE19 - Fetch snapshots after command, returns control then counter, repeating.
// RULE20 - Load: control byte at once; counter bytes take effect at reset.
// RULE21 - One fixed-length low pulse each time count hits interval multiple.
// RULE22 - One-second tick from crystal by a 15-bit prescaler.
`timescale 1ns/100ps
module srtc_core #(
  parameter logic [7:0]  FAMILY_CODE   = 8'h5A,             // Arbitrary value
  parameter logic [47:0] SERIAL_CODE   = 48'h0000_1234_5678, // Arbitrary value
  parameter int unsigned INT_PULSE_CYC = srtc_pkg::INT_PULSE_CYC
) (
  input  wire logic  i_clk,
  input  wire logic  i_nrst,
  input  wire logic  i_xtal,
  input  wire logic  i_bus_reset,
  input  wire logic  i_slot_start,
  input  wire logic  i_slot_sample,
  input  wire logic  i_slot_bit,
  input  wire logic  i_slot_end,
  output logic       o_dq_out,
  output logic       o_dq_oe_n,
  output logic       o_int_out,
  output logic       o_int_oe_n,
  output logic       o_id_ok
);
  srtc_tk_if tk ();

  srtc_pkg::srtc_state_t           state;
  logic [srtc_pkg::BITCNT_W-1:0]   bitcnt;
  logic [7:0]                      rx_byte;
  logic [7:0]                      next_byte;
  logic [7:0]                      check_byte;
  logic [7:0]                      crc;
  logic [srtc_pkg::ID_BITS-1:0]    id_code;
  logic [srtc_pkg::FRAME_BITS-1:0] fetch_frame;
  logic [7:0]                      ctrl_read;
  logic [1:0]                      enum_phase;
  logic                            run;
  logic [2:0]                      isel;
  logic                            gate;
  logic                            load_full;
  logic                            tx_bit;
  logic                            tx_state;
  logic                            drive_low;
  logic                            int_low;
  logic                            crc_shift;
  logic                            crc_bit;
  logic                            byte_done;
  logic                            id_done;
  logic [srtc_pkg::SEC_W-1:0]      load_buf;
  logic                            snap_req;
  logic                            load_req;

  assign id_code = {check_byte, SERIAL_CODE, FAMILY_CODE}; // RULE1
  assign ctrl_read = {gate, isel, run, run, 2'b00}; // RULE11 RULE12
  assign fetch_frame = {tk.snapshot, ctrl_read}; // RULE19
  assign next_byte = {i_slot_bit, rx_byte[7:1]}; // RULE6
  assign byte_done = i_slot_sample && (bitcnt == 7'(srtc_pkg::BYTE_BITS - 1));
  assign id_done = bitcnt == 7'(srtc_pkg::ID_BITS - 1);

  // Self-check of the identity at start-up: 56 bits give the check byte,
  // the last 8 must bring the register back to zero
  assign crc_shift = (state == srtc_pkg::SRTC_INIT);
  assign crc_bit = (bitcnt < 7'(srtc_pkg::CHECK_POS)) ? id_code[bitcnt[5:0]]
                   : (bitcnt == 7'(srtc_pkg::CHECK_POS)) ? crc[0] : check_byte[bitcnt[2:0]];

  srtc_crc8 u_crc (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_clear (1'b0),
    .i_shift (crc_shift),
    .i_bit   (crc_bit),
    .o_crc   (crc)
  );

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      check_byte <= 8'h00;
      o_id_ok    <= 1'b0;
    end else if (crc_shift) begin
      if (bitcnt == 7'(srtc_pkg::CHECK_POS)) begin
        check_byte <= crc; // RULE4
      end
      if (id_done) begin
        o_id_ok <= ((crc >> 1) ^ ((crc[0] ^ check_byte[7]) ? srtc_pkg::CRC_POLY_REFL
                   : 8'h00)) == 8'h00; // RULE5
      end
    end
  end

  // Bit to present in a read slot
  always_comb begin
    tx_state = 1'b0;
    tx_bit = 1'b1;
    unique case (state)
      srtc_pkg::SRTC_ID_READ: begin
        tx_state = 1'b1;
        tx_bit = id_code[bitcnt[5:0]]; // RULE6
      end
      srtc_pkg::SRTC_ENUM: begin
        tx_state = (enum_phase != 2'h2);
        tx_bit = id_code[bitcnt[5:0]] ^ enum_phase[0];
      end
      srtc_pkg::SRTC_FETCH: begin
        tx_state = 1'b1;
        tx_bit = fetch_frame[bitcnt[5:0]]; // RULE19
      end
      default: begin
        tx_state = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end

  // Pull low for the whole slot on a zero, else leave released
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      drive_low <= 1'b0;
    end else if (i_bus_reset || i_slot_end) begin
      drive_low <= 1'b0;
    end else if (i_slot_start && tx_state && !tx_bit) begin
      drive_low <= 1'b1; // RULE16
    end
  end

  assign o_dq_out   = 1'b0; // RULE16
  assign o_dq_oe_n  = ~drive_low;
  assign o_int_out  = 1'b0; // RULE15
  assign o_int_oe_n = ~int_low; // RULE15

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_byte <= 8'h00;
    end else if (i_slot_sample) begin
      rx_byte <= next_byte;
    end
  end

  // Command and transfer sequencing
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state      <= srtc_pkg::SRTC_INIT;
      bitcnt     <= '0;
      enum_phase <= 2'h0;
    end else if (state == srtc_pkg::SRTC_INIT) begin
      bitcnt <= id_done ? '0 : bitcnt + 7'h01; // RULE3
      if (id_done) begin
        state <= srtc_pkg::SRTC_IDLE;
      end
    end else if (i_bus_reset) begin
      state      <= srtc_pkg::SRTC_ROM_CMD;
      bitcnt     <= '0;
      enum_phase <= 2'h0;
    end else if (i_slot_sample) begin
      unique case (state)
        srtc_pkg::SRTC_ROM_CMD: begin
          bitcnt <= byte_done ? '0 : bitcnt + 7'h01;
          if (byte_done) begin
            unique case (next_byte)
              srtc_pkg::CMD_ID_READOUT:  state <= srtc_pkg::SRTC_ID_READ;
              srtc_pkg::CMD_ADDR_SELECT: state <= srtc_pkg::SRTC_ADDR_MATCH;
              srtc_pkg::CMD_ENUMERATION: state <= srtc_pkg::SRTC_ENUM;
              srtc_pkg::CMD_BCAST_SEL:   state <= srtc_pkg::SRTC_FN_CMD; // RULE7
              default:                   state <= srtc_pkg::SRTC_WAIT;
            endcase
          end
        end
        srtc_pkg::SRTC_ID_READ: begin
          bitcnt <= id_done ? '0 : bitcnt + 7'h01;
          if (id_done) begin
            state <= srtc_pkg::SRTC_FN_CMD; // RULE7
          end
        end
        srtc_pkg::SRTC_ADDR_MATCH: begin
          bitcnt <= id_done ? '0 : bitcnt + 7'h01;
          if (i_slot_bit != id_code[bitcnt[5:0]]) begin
            state <= srtc_pkg::SRTC_WAIT;
          end else if (id_done) begin
            state <= srtc_pkg::SRTC_FN_CMD; // RULE7
          end
        end
        srtc_pkg::SRTC_ENUM: begin
          if (enum_phase != 2'h2) begin
            enum_phase <= enum_phase + 2'h1;
          end else begin
            enum_phase <= 2'h0;
            bitcnt <= id_done ? '0 : bitcnt + 7'h01;
            if (i_slot_bit != id_code[bitcnt[5:0]]) begin
              state <= srtc_pkg::SRTC_WAIT;
            end else if (id_done) begin
              state <= srtc_pkg::SRTC_FN_CMD; // RULE7
            end
          end
        end
        srtc_pkg::SRTC_FN_CMD: begin
          bitcnt <= byte_done ? '0 : bitcnt + 7'h01;
          if (byte_done) begin
            unique case (next_byte)
              srtc_pkg::CMD_TIME_FETCH: state <= srtc_pkg::SRTC_FETCH; // RULE10
              srtc_pkg::CMD_TIME_LOAD:  state <= srtc_pkg::SRTC_LOAD; // RULE10
              default:                  state <= srtc_pkg::SRTC_WAIT;
            endcase
          end
        end
        srtc_pkg::SRTC_FETCH: begin
          bitcnt <= (bitcnt == 7'(srtc_pkg::FRAME_BITS - 1)) ? '0
                    : bitcnt + 7'h01; // RULE19
        end
        srtc_pkg::SRTC_LOAD: begin
          bitcnt <= bitcnt + 7'h01;
          if (bitcnt == 7'(srtc_pkg::FRAME_BITS - 1)) begin
            state <= srtc_pkg::SRTC_WAIT;
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  assign snap_req = i_slot_sample && byte_done && (state == srtc_pkg::SRTC_FN_CMD)
                    && (next_byte == srtc_pkg::CMD_TIME_FETCH); // RULE9 RULE19

  // Control byte, written only from a load transfer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run  <= srtc_pkg::RST_RUN;
      isel <= srtc_pkg::RST_ISEL;
      gate <= srtc_pkg::RST_GATE;
    end else if (state == srtc_pkg::SRTC_LOAD && byte_done && bitcnt[6:3] == 4'h0) begin
      run  <= next_byte[srtc_pkg::CTL_RUN_HI]; // RULE13 RULE20
      isel <= next_byte[srtc_pkg::CTL_ISEL_LSB +: 3]; // RULE14
      gate <= next_byte[srtc_pkg::CTL_GATE]; // RULE17
    end
  end

  // Counter bytes wait in a buffer until the next bus reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      load_buf  <= '0;
      load_full <= 1'b0;
    end else if (i_bus_reset) begin
      load_full <= 1'b0;
    end else if (state == srtc_pkg::SRTC_LOAD && i_slot_sample
                 && bitcnt >= 7'(srtc_pkg::BYTE_BITS)) begin
      load_buf  <= {i_slot_bit, load_buf[srtc_pkg::SEC_W-1:1]}; // RULE6
      load_full <= (bitcnt == 7'(srtc_pkg::FRAME_BITS - 1));
    end
  end

  assign load_req = i_bus_reset && load_full; // RULE20

  assign tk.osc_en   = run;
  assign tk.isel     = isel;
  assign tk.irq_en   = gate;
  assign tk.snap_req = snap_req;
  assign tk.load_req = load_req;
  assign tk.load_val = load_buf;

  srtc_timekeeper #(
    .INT_PULSE_CYC (INT_PULSE_CYC)
  ) u_tk (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_xtal    (i_xtal),
    .tk        (tk.tk),
    .o_int_low (int_low)
  );
endmodule : srtc_core

// >>> srtc_core_assertions.sv
// Checker on the core's pins: open-drain use, slot answers, interrupt pulse.
// Assumes slot-layer pulses keep the order start, sample, end.
`timescale 1ns/100ps
module srtc_core_assertions #(
  parameter int unsigned INT_PULSE_CYC = 20
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_xtal,
  input wire logic i_bus_reset,
  input wire logic i_slot_start,
  input wire logic i_slot_sample,
  input wire logic i_slot_bit,
  input wire logic i_slot_end,
  input wire logic o_dq_out,
  input wire logic o_dq_oe_n,
  input wire logic o_int_out,
  input wire logic o_int_oe_n,
  input wire logic o_id_ok
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  int unsigned low_cnt;
  int unsigned up_cnt;
  logic [15:0] x_hist;

  // Low pulse length, cleared while released
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_cnt <= 0;
    end else if (!o_int_oe_n) begin
      low_cnt <= low_cnt + 1;
    end else begin
      low_cnt <= 0;
    end
  end

  // Saturates so it never wraps in a long run
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      up_cnt <= 0;
    end else if (up_cnt < 100) begin
      up_cnt <= up_cnt + 1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      x_hist <= 16'h0000;
    end else begin
      x_hist <= {x_hist[14:0], i_xtal};
    end
  end

  sequence slot_close;
    i_slot_end ##1 o_dq_oe_n;
  endsequence
  sequence pulse_begin;
    $fell(o_int_oe_n);
  endsequence

  a_dq_low_only: assert property (o_dq_out == 1'b0)
    else $error("data pin driven high");
  a_int_low_only: assert property (o_int_out == 1'b0)
    else $error("interrupt pin driven high");
  a_slot_release: assert property (i_slot_end |-> slot_close)
    else $error("data pin held after slot end");
  a_pull_after_start: assert property ($fell(o_dq_oe_n) |-> $past(i_slot_start))
    else $error("data pin pulled outside slot start");
  a_reset_release: assert property (i_bus_reset |=> o_dq_oe_n)
    else $error("data pin held after bus reset");
  a_quiet_before_id: assert property (!o_id_ok |-> o_dq_oe_n)
    else $error("bus answered during self-check");
  a_id_ok_time: assert property ((up_cnt == 70) |-> o_id_ok)
    else $error("identity self-check not done");
  a_id_ok_holds: assert property ($rose(o_id_ok) |=> o_id_ok [*8])
    else $error("identity flag dropped");
  a_pulse_length: assert property ($rose(o_int_oe_n) |-> low_cnt == INT_PULSE_CYC)
    else $error("interrupt pulse length wrong");
  a_pulse_cap: assert property (low_cnt <= INT_PULSE_CYC)
    else $error("interrupt pulse too long");
  a_tick_from_xtal: assert property (pulse_begin |-> |(x_hist[14:0] & ~x_hist[15:1]))
    else $error("interrupt without crystal edges");
endmodule : srtc_core_assertions

bind srtc_core srtc_core_assertions #(.INT_PULSE_CYC(INT_PULSE_CYC)) u_srtc_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_xtal(i_xtal), .i_bus_reset(i_bus_reset),
  .i_slot_start(i_slot_start), .i_slot_sample(i_slot_sample), .i_slot_bit(i_slot_bit),
  .i_slot_end(i_slot_end), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n),
  .o_int_out(o_int_out), .o_int_oe_n(o_int_oe_n), .o_id_ok(o_id_ok));

// >>> srtc_master_model.sv
// Bus master model at slot level: resets, write slots and read slots.
// Assumes a pull-up on the data line; the core only pulls it low.
`timescale 1ns/100ps
module srtc_master_model (
  input  wire logic i_clk,
  input  wire logic i_dq_oe_n,
  input  wire logic i_dq_out,
  output logic      o_bus_reset,
  output logic      o_slot_start,
  output logic      o_slot_sample,
  output logic      o_slot_bit,
  output logic      o_slot_end
);
  logic line;
  assign line = i_dq_oe_n ? 1'b1 : i_dq_out;

  initial begin
    o_bus_reset = 1'b0;
    o_slot_start = 1'b0;
    o_slot_sample = 1'b0;
    o_slot_bit = 1'b0;
    o_slot_end = 1'b0;
  end

  task automatic step();
    @(posedge i_clk);
    #1;
  endtask : step

  // Two spare cycles before sampling let the answer settle
  task automatic slot(input logic wr, input logic b, output logic got);
    step();
    o_slot_start = 1'b1;
    step();
    o_slot_start = 1'b0;
    step();
    step();
    got = wr ? b : line;
    o_slot_sample = 1'b1;
    o_slot_bit = got;
    step();
    o_slot_sample = 1'b0;
    o_slot_end = 1'b1;
    step();
    o_slot_end = 1'b0;
  endtask : slot

  task automatic bus_rst();
    step();
    o_bus_reset = 1'b1;
    step();
    o_bus_reset = 1'b0;
  endtask : bus_rst

  task automatic wr_bits(input logic [63:0] v, input int n);
    logic g;
    for (int i = 0; i < n; i++) begin
      slot(1'b1, v[i], g);
    end
  endtask : wr_bits

  task automatic rd_bits(input int n, output logic [63:0] v);
    logic g;
    v = 64'h0;
    for (int i = 0; i < n; i++) begin
      slot(1'b0, 1'b0, g);
      v[i] = g;
    end
  endtask : rd_bits
endmodule : srtc_master_model

// >>> single_wire_rtc_core_tb_top.sv
// Testbench for the real-time clock core with a slot-level master model.
// Assumes the crystal input may run at half the core clock to shorten a second.
`timescale 1ns/100ps
module single_wire_rtc_core_tb_top;
  localparam logic [7:0]  FAM  = 8'h3C;               // Arbitrary value
  localparam logic [47:0] SER  = 48'h0000_00A5_C3E1;  // Arbitrary value
  localparam logic [7:0]  SKIP = srtc_pkg::CMD_BCAST_SEL;
  localparam logic [39:0] ONES = 40'hFF_FFFF_FFFF;
  typedef struct packed {logic [7:0] ctl; logic [31:0] cnt; logic [7:0] exp;} srtc_row_t;
  localparam srtc_row_t ROWS [9] = '{
    '{8'h03, 32'hA5A5_0F0F, 8'h00}, '{8'h14, 32'h0000_0001, 8'h10},
    '{8'h20, 32'h8000_0000, 8'h20}, '{8'h33, 32'h1234_5678, 8'h30},
    '{8'h40, 32'hFFFF_FFFE, 8'h40}, '{8'h51, 32'h00FF_00FF, 8'h50},
    '{8'h62, 32'h7FFF_FFFF, 8'h60}, '{8'hF0, 32'hC3C3_3C3C, 8'hF0},
    '{8'h08, 32'h0101_0101, 8'h0C}};

  logic i_clk, i_nrst, i_xtal, i_bus_reset, i_slot_start, i_slot_sample, i_slot_bit;
  logic i_slot_end, o_dq_out, o_dq_oe_n, o_int_out, o_int_oe_n, o_id_ok;
  int bad_count = 0;
  int total_checks = 0;
  logic [39:0] v, w;
  logic [63:0] r, id;

  srtc_core #(.FAMILY_CODE(FAM), .SERIAL_CODE(SER), .INT_PULSE_CYC(20)) i_dut (
    .i_clk, .i_nrst, .i_xtal, .i_bus_reset, .i_slot_start, .i_slot_sample,
    .i_slot_bit, .i_slot_end, .o_dq_out, .o_dq_oe_n, .o_int_out, .o_int_oe_n, .o_id_ok);
  srtc_master_model u_mst (.i_clk, .i_dq_oe_n(o_dq_oe_n), .i_dq_out(o_dq_out),
    .o_bus_reset(i_bus_reset), .o_slot_start(i_slot_start), .o_slot_sample(i_slot_sample),
    .o_slot_bit(i_slot_bit), .o_slot_end(i_slot_end));

  always #2.5 i_clk = ~i_clk;
  // Fastest crystal the input synchroniser still resolves
  always @(posedge i_clk) i_xtal <= #1 ~i_xtal;

  function automatic logic [7:0] crc_of(input logic [63:0] d, input int n);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      fb = c[0] ^ d[i];
      c = {1'b0, c[7:1]} ^ (fb ? 8'h8C : 8'h00);
    end
    return c;
  endfunction : crc_of

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic hdr(input logic [7:0] a);
    u_mst.bus_rst();
    u_mst.wr_bits({56'h0, a}, 8);
  endtask : hdr

  // Counter bytes only count once all four have arrived
  task automatic load(input logic [7:0] c, input logic [31:0] n, input int nb);
    hdr(SKIP);
    u_mst.wr_bits({56'h0, srtc_pkg::CMD_TIME_LOAD}, 8);
    u_mst.wr_bits({56'h0, c}, 8);
    u_mst.wr_bits({32'h0, n}, nb * 8);
    u_mst.bus_rst();
  endtask : load

  task automatic fetch(output logic [39:0] d);
    hdr(SKIP);
    u_mst.wr_bits({56'h0, srtc_pkg::CMD_TIME_FETCH}, 8);
    u_mst.rd_bits(40, r);
    d = r[39:0];
  endtask : fetch

  initial begin
    #450000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    i_xtal = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    repeat (80) u_mst.step();
    for (int k = 0; k < 9; k++) begin
      load(ROWS[k].ctl, ROWS[k].cnt, 4);
      fetch(v);
      check(v, {ROWS[k].cnt, ROWS[k].exp});
      $display("row %0d done", k);
    end
    i_nrst = 1'b0;
    repeat (2) u_mst.step();
    i_nrst = 1'b1;
    repeat (80) u_mst.step();
    check(o_id_ok, 1'b1);
    fetch(v);
    u_mst.rd_bits(40, r);
    check(v, 40'h0);
    check(r[39:0], v);
    $display("reset test done");
    id = {crc_of({8'h0, SER, FAM}, 56), SER, FAM};
    hdr(srtc_pkg::CMD_ID_READOUT);
    u_mst.rd_bits(64, r);
    check(r, id);
    check(crc_of(r, 64), 8'h00);
    for (int k = 0; k < 2; k++) begin
      hdr(srtc_pkg::CMD_ADDR_SELECT);
      u_mst.wr_bits(id ^ (64'(k) << 10), 64);
      u_mst.wr_bits({56'h0, srtc_pkg::CMD_TIME_FETCH}, 8);
      u_mst.rd_bits(40, r);
      check(r[39:0], k ? ONES : 40'h0);
    end
    hdr(srtc_pkg::CMD_TIME_FETCH);
    u_mst.rd_bits(40, r);
    check(r[39:0], ONES);
    // Enumeration: bit, complement, then the master's choice of bit
    hdr(srtc_pkg::CMD_ENUMERATION);
    for (int k = 0; k < 64; k++) begin
      u_mst.rd_bits(2, r);
      check(r[1:0], {~id[k], id[k]});
      u_mst.wr_bits({63'h0, id[k]}, 1);
    end
    u_mst.wr_bits({56'h0, srtc_pkg::CMD_TIME_FETCH}, 8);
    u_mst.rd_bits(40, r);
    check(r[39:0], 40'h0);
    $display("identity test done");
    load(8'h00, 32'h1357_9BDF, 4);
    load(8'h00, 32'hDEAD_BEEF, 2);
    fetch(v);
    check(v, {32'h1357_9BDF, 8'h00});
    $display("partial load test done");
    load(8'h89, 32'hFFFF_FFFF, 4);
    for (int k = 0; k < 70000 && o_int_oe_n !== 1'b0; k++) u_mst.step();
    check(o_int_oe_n, 1'b0);
    if (o_int_oe_n !== 1'b0) tally_and_finish();
    fetch(w);
    check(w, {32'h0, 8'h8C});
    $display("tick test done");
    tally_and_finish();
  end
endmodule : single_wire_rtc_core_tb_top
